// File: rtl/mq_params.svh
// offsets, field positions, reset values and sizes of the slotted message queue
`ifndef MQ_PARAMS_SVH
`define MQ_PARAMS_SVH
// ----------------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------------
`define MQ_SLOTS          16
`define MQ_WORDS          128
`define MQ_DEPTH          2
`define MQ_FIFO_DEPTH     16
// ----------------------------------------------------------------------------
// address windows (byte address bits 15:14 pick a slot window; the global window needs bits 15:12 at zero)
// ----------------------------------------------------------------------------
`define MQ_WIN_GLOBAL     4'h0
`define MQ_WIN_IN         2'h1
`define MQ_WIN_OUT        2'h2
`define MQ_GLB_SLOT_COUNT 12'h000
`define MQ_GLB_STATUS     12'h004
`define MQ_GLB_IRQ_MASK   12'h008
`define MQ_GLB_COALESCE   12'h00C
// word index inside a 1 KiB slot window; payload sits in the upper half
`define MQ_REG_COMMAND    8'h00
`define MQ_REG_STATUS     8'h01
`define MQ_REG_DEST_IP    8'h02
`define MQ_REG_DEST_PORT  8'h03
`define MQ_REG_REMOTE_ADR 8'h04
`define MQ_DATA_BASE      32'h0000_0200
// ----------------------------------------------------------------------------
// command and status fields
// ----------------------------------------------------------------------------
`define MQ_CMD_CLAIM      0
`define MQ_CMD_READY      1
`define MQ_CMD_DISCARD    2
`define MQ_CMD_PURGE      3
`define MQ_CMD_SIZE_LSB   16
`define MQ_ST_FULL        0
`define MQ_ST_EMPTY       1
`define MQ_ST_COUNT_LSB   8
`define MQ_ST_SIZE_LSB    16
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define MQ_MASK_RST       32'h0000_0000
`define MQ_COAL_RST       32'h0000_0000
`define MQ_TGT_RST        32'h0000_0000
`endif

// File: rtl/mq_pkg.sv
// types shared by the slotted message queue
package mq_pkg;
  // bus request as seen by a slave, or driven by the network master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } wb_req_s;
  // slave answer
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;
  // one write queued toward the network master core
  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
  } net_word_s;
  // message transmit sequencer of the network-side variant
  typedef enum logic [2:0] {TX_IDLE, TX_CLAIM, TX_DATA, TX_READY, TX_DONE} tx_state_e;
endpackage : mq_pkg

// File: rtl/slotted_message_queue.sv
// slotted message queue: slot storage, outbound fifo and the queue top level
`timescale 1ns/1ps
`include "mq_params.svh"

// ----------------------------------------------------------------------------
// outbound fifo
// ----------------------------------------------------------------------------
module mq_fifo #(
  parameter int W     = 64,
  parameter int DEPTH = `MQ_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW:0]  wr_q;
  logic [PW:0]  rd_q;

  // extra pointer bit tells full from empty
  assign in_ready  = !((wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[PW-1:0]];

  // pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) wr_q <= wr_q + (PW+1)'(1);
      if (out_valid && out_ready) rd_q <= rd_q + (PW+1)'(1);
    end
  end

  // storage
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) mem[wr_q[PW-1:0]] <= in_data;
  end
endmodule : mq_fifo

// ----------------------------------------------------------------------------
// one slot: a ring of DEPTH messages of up to 128 words
// ----------------------------------------------------------------------------
module mq_slot #(
  parameter int DEPTH = `MQ_DEPTH
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // producer side
  input  wire logic        p_claim,
  input  wire logic        p_ready,
  input  wire logic [7:0]  p_size,
  input  wire logic        p_we,
  input  wire logic [6:0]  p_idx,
  input  wire logic [31:0] p_wdata,
  input  wire logic        p_err,
  output logic [31:0]      p_rdata,
  // consumer side
  input  wire logic        c_discard,
  input  wire logic [6:0]  c_idx,
  output logic [31:0]      c_rdata,
  // either side
  input  wire logic        purge,
  // state
  output logic             full,
  output logic             empty,
  output logic [7:0]       count,
  output logic [7:0]       head_size
);
  localparam int PW = $clog2(DEPTH);
  logic [31:0]   mem [DEPTH*`MQ_WORDS];
  logic [7:0]    len_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [7:0]    cnt_q;
  logic          claimed_q;
  logic          tainted_q;
  logic          push;
  logic          pop;

  assign full      = (cnt_q == 8'(DEPTH));
  assign empty     = (cnt_q == 8'h00);
  assign count     = cnt_q;
  assign head_size = empty ? 8'h00 : len_q[rd_q];
  assign p_rdata   = mem[{wr_q, p_idx}];
  assign c_rdata   = mem[{rd_q, c_idx}];

  // a commit on a full slot or of a tainted message is dropped silently
  assign push = p_ready && !p_claim && claimed_q && !tainted_q && !full && !purge;
  // a claim on a full slot frees the oldest entry; a discard in the same cycle already does
  assign pop  = ((c_discard && !empty) || (p_claim && full)) && !purge;

  // ring pointers and message count
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= 8'h00;
    end else if (purge) begin
      rd_q  <= wr_q;
      cnt_q <= 8'h00;
    end else begin
      if (push) wr_q <= wr_q + PW'(1);
      if (pop) rd_q <= rd_q + PW'(1);
      cnt_q <= cnt_q + 8'(push) - 8'(pop);
    end
  end

  // assembly state: a new claim restarts whatever was being built
  always_ff @(posedge clk) begin
    if (rst) begin
      claimed_q <= 1'b0;
      tainted_q <= 1'b0;
    end else if (purge) begin
      claimed_q <= 1'b0;
      tainted_q <= 1'b0;
    end else if (p_claim) begin
      claimed_q <= 1'b1;
      tainted_q <= 1'b0;
    end else begin
      if (p_ready) claimed_q <= 1'b0;
      if (p_err && claimed_q) tainted_q <= 1'b1;
    end
  end

  // payload and length storage; payload needs no reset
  always_ff @(posedge clk) begin
    if (p_we) mem[{wr_q, p_idx}] <= p_wdata;
    if (push) len_q[wr_q] <= p_size;
  end
endmodule : mq_slot

// ----------------------------------------------------------------------------
// queue top level
// ----------------------------------------------------------------------------
module slotted_message_queue #(
  parameter bit REMOTE = 1'b0  // 0: host-side queue, 1: network-side queue
) (
  // clock and reset
  input  wire logic            CORE_CLK,
  input  wire logic            RST,
  // cpu slave port
  input  wire mq_pkg::wb_req_s CPU_REQ,
  output mq_pkg::wb_rsp_s      CPU_RSP,
  // host slave port, or remote-write slave port in the network variant
  input  wire mq_pkg::wb_req_s HOST_REQ,
  output mq_pkg::wb_rsp_s      HOST_RSP,
  input  wire logic            HOST_ERR,
  // network master port
  output mq_pkg::wb_req_s      NET_REQ,
  input  wire logic            NET_ACK,
  output logic [31:0]          NET_IP,
  output logic [31:0]          NET_PORT,
  // host interrupt and cpu polling
  output logic                 IRQ,
  output logic [15:0]          POLL
);
  localparam int NS = `MQ_SLOTS;

  // ----------------------------------------------------------------------------
  // address decode, one set per slave port
  // ----------------------------------------------------------------------------
  logic       c_ack_q, h_ack_q;
  logic       c_acc, c_wr, h_acc, h_wr;
  logic [3:0] c_slot, h_slot;
  logic [6:0] c_idx, h_idx;
  logic       c_cmd_in, c_cmd_out, c_dat_out, h_cmd_in, h_cmd_out, h_dat_in;
  logic       h_out_ok;

  // classic single-cycle handshake: a request is taken once, ack follows
  assign c_acc  = CPU_REQ.cyc && CPU_REQ.stb && !c_ack_q;
  assign h_acc  = HOST_REQ.cyc && HOST_REQ.stb && !h_ack_q;
  assign c_wr   = c_acc && CPU_REQ.we;
  assign h_wr   = h_acc && HOST_REQ.we;
  assign c_slot = CPU_REQ.adr[13:10];
  assign h_slot = HOST_REQ.adr[13:10];
  assign c_idx  = CPU_REQ.adr[8:2];
  assign h_idx  = HOST_REQ.adr[8:2];
  // the remote-write port of the network variant reaches incoming slots only
  assign h_out_ok = !REMOTE;

  assign c_cmd_in  = c_wr && CPU_REQ.adr[15:14] == `MQ_WIN_IN && !CPU_REQ.adr[9]
                     && CPU_REQ.adr[9:2] == `MQ_REG_COMMAND;
  assign c_cmd_out = c_wr && CPU_REQ.adr[15:14] == `MQ_WIN_OUT && !CPU_REQ.adr[9]
                     && CPU_REQ.adr[9:2] == `MQ_REG_COMMAND;
  assign c_dat_out = c_wr && CPU_REQ.adr[15:14] == `MQ_WIN_OUT && CPU_REQ.adr[9];
  assign h_cmd_in  = h_wr && HOST_REQ.adr[15:14] == `MQ_WIN_IN && !HOST_REQ.adr[9]
                     && HOST_REQ.adr[9:2] == `MQ_REG_COMMAND;
  assign h_cmd_out = h_wr && h_out_ok && HOST_REQ.adr[15:14] == `MQ_WIN_OUT
                     && !HOST_REQ.adr[9] && HOST_REQ.adr[9:2] == `MQ_REG_COMMAND;
  assign h_dat_in  = h_wr && HOST_REQ.adr[15:14] == `MQ_WIN_IN && HOST_REQ.adr[9];

  // ----------------------------------------------------------------------------
  // slot arrays
  // ----------------------------------------------------------------------------
  logic [31:0] in_prd [NS];
  logic [31:0] in_crd [NS];
  logic [31:0] out_prd [NS];
  logic [31:0] out_crd [NS];
  logic [NS-1:0] in_full, in_empty, out_full, out_empty;
  logic [7:0]  in_cnt [NS];
  logic [7:0]  in_hsz [NS];
  logic [7:0]  out_cnt [NS];
  logic [7:0]  out_hsz [NS];
  logic [31:0] tgt_ip_q [NS];
  logic [31:0] tgt_port_q [NS];
  logic [31:0] tgt_adr_q [NS];
  mq_pkg::tx_state_e tx_q;
  logic [3:0]  e_slot_q;
  logic [7:0]  e_idx_q;
  logic [6:0]  out_cidx;

  assign out_cidx = REMOTE ? e_idx_q[6:0] : h_idx;

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_slot
      logic ih, ic, oc, oh;
      assign ih = h_cmd_in && h_slot == 4'(gi);
      assign ic = c_cmd_in && c_slot == 4'(gi);
      assign oc = c_cmd_out && c_slot == 4'(gi);
      assign oh = h_cmd_out && h_slot == 4'(gi);

      // incoming: host or remote writer fills, cpu drains
      mq_slot #(.DEPTH(`MQ_DEPTH)) u_in (
        .clk       (CORE_CLK),
        .rst       (RST),
        .p_claim   (ih && HOST_REQ.dat[`MQ_CMD_CLAIM]),
        .p_ready   (ih && HOST_REQ.dat[`MQ_CMD_READY]),
        .p_size    (HOST_REQ.dat[`MQ_CMD_SIZE_LSB +: 8]),
        .p_we      (h_dat_in && h_slot == 4'(gi)),
        .p_idx     (h_idx),
        .p_wdata   (HOST_REQ.dat),
        .p_err     (HOST_ERR && h_acc && h_slot == 4'(gi)),
        .p_rdata   (in_prd[gi]),
        .c_discard (ic && CPU_REQ.dat[`MQ_CMD_DISCARD]),
        .c_idx     (c_idx),
        .c_rdata   (in_crd[gi]),
        .purge     ((ih && HOST_REQ.dat[`MQ_CMD_PURGE]) || (ic && CPU_REQ.dat[`MQ_CMD_PURGE])),
        .full      (in_full[gi]),
        .empty     (in_empty[gi]),
        .count     (in_cnt[gi]),
        .head_size (in_hsz[gi])
      );

      // outgoing: cpu fills, host or the network sequencer drains
      mq_slot #(.DEPTH(`MQ_DEPTH)) u_out (
        .clk       (CORE_CLK),
        .rst       (RST),
        .p_claim   (oc && CPU_REQ.dat[`MQ_CMD_CLAIM]),
        .p_ready   (oc && CPU_REQ.dat[`MQ_CMD_READY]),
        .p_size    (CPU_REQ.dat[`MQ_CMD_SIZE_LSB +: 8]),
        .p_we      (c_dat_out && c_slot == 4'(gi)),
        .p_idx     (c_idx),
        .p_wdata   (CPU_REQ.dat),
        .p_err     (1'b0),
        .p_rdata   (out_prd[gi]),
        .c_discard (REMOTE ? (tx_q == mq_pkg::TX_DONE && e_slot_q == 4'(gi))
                           : (oh && HOST_REQ.dat[`MQ_CMD_DISCARD])),
        .c_idx     (out_cidx),
        .c_rdata   (out_crd[gi]),
        .purge     ((oc && CPU_REQ.dat[`MQ_CMD_PURGE]) || (oh && HOST_REQ.dat[`MQ_CMD_PURGE])),
        .full      (out_full[gi]),
        .empty     (out_empty[gi]),
        .count     (out_cnt[gi]),
        .head_size (out_hsz[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // global and target registers
  // ----------------------------------------------------------------------------
  logic [31:0] mask_q, coal_q, slot_status;

  assign slot_status = {~out_full, ~in_empty};

  // mask and coalescing control are writable from either port
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mask_q <= `MQ_MASK_RST;
      coal_q <= `MQ_COAL_RST;
    end else begin
      if (c_wr && CPU_REQ.adr[15:12] == `MQ_WIN_GLOBAL) begin
        if (CPU_REQ.adr[11:0] == `MQ_GLB_IRQ_MASK) mask_q <= CPU_REQ.dat;
        if (CPU_REQ.adr[11:0] == `MQ_GLB_COALESCE) coal_q <= CPU_REQ.dat;
      end
      if (h_wr && HOST_REQ.adr[15:12] == `MQ_WIN_GLOBAL) begin
        if (HOST_REQ.adr[11:0] == `MQ_GLB_IRQ_MASK) mask_q <= HOST_REQ.dat;
        if (HOST_REQ.adr[11:0] == `MQ_GLB_COALESCE) coal_q <= HOST_REQ.dat;
      end
    end
  end

  // destination settings of outgoing slots, written by the cpu
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      for (int i = 0; i < NS; i++) begin
        tgt_ip_q[i]   <= `MQ_TGT_RST;
        tgt_port_q[i] <= `MQ_TGT_RST;
        tgt_adr_q[i]  <= `MQ_TGT_RST;
      end
    end else if (c_wr && CPU_REQ.adr[15:14] == `MQ_WIN_OUT && !CPU_REQ.adr[9]) begin
      case (CPU_REQ.adr[9:2])
        `MQ_REG_DEST_IP:    tgt_ip_q[c_slot]   <= CPU_REQ.dat;
        `MQ_REG_DEST_PORT:  tgt_port_q[c_slot] <= CPU_REQ.dat;
        `MQ_REG_REMOTE_ADR: tgt_adr_q[c_slot]  <= CPU_REQ.dat;
        default: ;
      endcase
    end
  end

  // read mux shared by both ports; the host side sees the mirrored view
  function automatic logic [31:0] rd_word(input logic [31:0] adr, input logic hs);
    logic [3:0]  s;
    logic        o;
    logic [31:0] r;
    s = adr[13:10];
    o = (adr[15:14] == `MQ_WIN_OUT);
    r = 32'h0000_0000;
    if (adr[15:12] == `MQ_WIN_GLOBAL) begin
      case (adr[11:0])
        `MQ_GLB_SLOT_COUNT: r = {16'h0000, 8'(NS), 8'(NS)};
        `MQ_GLB_STATUS:     r = slot_status;
        `MQ_GLB_IRQ_MASK:   r = mask_q;
        `MQ_GLB_COALESCE:   r = coal_q;
        default:            r = 32'h0000_0000;
      endcase
    end else if (adr[15:14] == `MQ_WIN_IN || (o && !(hs && REMOTE))) begin
      if (adr[9]) begin
        if (o) r = hs ? out_crd[s] : out_prd[s];
        else   r = hs ? in_prd[s] : in_crd[s];
      end else begin
        case (adr[9:2])
          `MQ_REG_STATUS: begin
            r[`MQ_ST_FULL]                = o ? out_full[s] : in_full[s];
            r[`MQ_ST_EMPTY]               = o ? out_empty[s] : in_empty[s];
            r[`MQ_ST_COUNT_LSB +: 8]      = o ? out_cnt[s] : in_cnt[s];
            r[`MQ_ST_SIZE_LSB +: 8]       = o ? out_hsz[s] : in_hsz[s];
          end
          `MQ_REG_DEST_IP:    r = o ? tgt_ip_q[s] : 32'h0000_0000;
          `MQ_REG_DEST_PORT:  r = o ? tgt_port_q[s] : 32'h0000_0000;
          `MQ_REG_REMOTE_ADR: r = o ? tgt_adr_q[s] : 32'h0000_0000;
          default:            r = 32'h0000_0000;
        endcase
      end
    end
    return r;
  endfunction : rd_word

  // answers: ack one cycle after the request, unmapped reads give zero
  logic [31:0] c_rd_q, h_rd_q;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      c_ack_q <= 1'b0;
      h_ack_q <= 1'b0;
      c_rd_q  <= 32'h0000_0000;
      h_rd_q  <= 32'h0000_0000;
    end else begin
      c_ack_q <= c_acc;
      h_ack_q <= h_acc;
      if (c_acc) c_rd_q <= rd_word(CPU_REQ.adr, 1'b0);
      if (h_acc) h_rd_q <= rd_word(HOST_REQ.adr, 1'b1);
    end
  end
  assign CPU_RSP  = '{ack: c_ack_q, dat: c_rd_q};
  assign HOST_RSP = '{ack: h_ack_q, dat: h_rd_q};

  // ----------------------------------------------------------------------------
  // interrupt and polling outputs
  // ----------------------------------------------------------------------------
  logic        irq_q;
  logic [15:0] poll_q;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      irq_q  <= 1'b0;
      poll_q <= 16'h0000;
    end else begin
      irq_q  <= !REMOTE && |(slot_status & mask_q);
      poll_q <= ~in_empty;
    end
  end
  assign IRQ  = irq_q;
  assign POLL = poll_q;

  // ----------------------------------------------------------------------------
  // network sequencer: claim, payload, ready, then discard locally
  // ----------------------------------------------------------------------------
  logic      [3:0] scan_q;
  logic      [7:0] e_len;
  logic      [31:0] ip_q, port_q;
  logic      f_in_valid, f_in_ready, f_out_valid;
  mq_pkg::net_word_s f_in, f_out;

  // a slot length above the payload size is clipped to the payload size
  assign e_len = (out_hsz[e_slot_q] > 8'(`MQ_WORDS)) ? 8'(`MQ_WORDS) : out_hsz[e_slot_q];

  // a new message starts only on a drained fifo so NET_IP/NET_PORT match its words
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tx_q     <= mq_pkg::TX_IDLE;
      scan_q   <= 4'h0;
      e_slot_q <= 4'h0;
      e_idx_q  <= 8'h00;
      ip_q     <= `MQ_TGT_RST;
      port_q   <= `MQ_TGT_RST;
    end else begin
      case (tx_q)
        mq_pkg::TX_IDLE: begin
          if (REMOTE && !f_out_valid) begin
            if (!out_empty[scan_q]) begin
              e_slot_q <= scan_q;
              e_idx_q  <= 8'h00;
              ip_q     <= tgt_ip_q[scan_q];
              port_q   <= tgt_port_q[scan_q];
              tx_q     <= mq_pkg::TX_CLAIM;
            end
            scan_q <= scan_q + 4'h1;
          end
        end
        mq_pkg::TX_CLAIM: begin
          if (f_in_ready) tx_q <= (e_len == 8'h00) ? mq_pkg::TX_READY : mq_pkg::TX_DATA;
        end
        mq_pkg::TX_DATA: begin
          if (f_in_ready) begin
            e_idx_q <= e_idx_q + 8'h01;
            if (e_idx_q == e_len - 8'h01) tx_q <= mq_pkg::TX_READY;
          end
        end
        mq_pkg::TX_READY: begin
          if (f_in_ready) tx_q <= mq_pkg::TX_DONE;
        end
        mq_pkg::TX_DONE: tx_q <= mq_pkg::TX_IDLE;
        default:         tx_q <= mq_pkg::TX_IDLE;
      endcase
    end
  end

  // remote writes that rebuild the message in the chosen remote slot
  always_comb begin
    f_in_valid = 1'b0;
    f_in.adr   = tgt_adr_q[e_slot_q];
    f_in.dat   = 32'h0000_0000;
    case (tx_q)
      mq_pkg::TX_CLAIM: begin
        f_in_valid                 = 1'b1;
        f_in.dat[`MQ_CMD_CLAIM]    = 1'b1;
      end
      mq_pkg::TX_DATA: begin
        f_in_valid = 1'b1;
        f_in.adr   = tgt_adr_q[e_slot_q] + `MQ_DATA_BASE + {22'h0, e_idx_q, 2'b00};
        f_in.dat   = out_crd[e_slot_q];
      end
      mq_pkg::TX_READY: begin
        f_in_valid                      = 1'b1;
        f_in.dat[`MQ_CMD_READY]         = 1'b1;
        f_in.dat[`MQ_CMD_SIZE_LSB +: 8] = e_len;
      end
      default: f_in_valid = 1'b0;
    endcase
  end

  mq_fifo #(.W($bits(mq_pkg::net_word_s)), .DEPTH(`MQ_FIFO_DEPTH)) u_fifo (
    .clk       (CORE_CLK),
    .rst       (RST),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in),
    .out_valid (f_out_valid),
    .out_ready (NET_ACK),
    .out_data  (f_out)
  );

  // network master: classic write cycle per fifo word, popped on ack
  assign NET_REQ  = '{cyc: f_out_valid, stb: f_out_valid, we: f_out_valid,
                      sel: {4{f_out_valid}}, adr: f_out.adr, dat: f_out.dat};
  assign NET_IP   = ip_q;
  assign NET_PORT = port_q;
endmodule : slotted_message_queue

// File: testbench/mq_checker_sva.sv
// port assertions for the slotted message queue
`timescale 1ns/1ps
module mq_checker #(parameter bit REMOTE = 1'b0) (
  // clock and reset
  input wire logic            CORE_CLK,
  input wire logic            RST,
  // slave ports
  input wire mq_pkg::wb_req_s CPU_REQ,
  input wire mq_pkg::wb_rsp_s CPU_RSP,
  input wire mq_pkg::wb_req_s HOST_REQ,
  input wire mq_pkg::wb_rsp_s HOST_RSP,
  // master link, interrupt, polling
  input wire mq_pkg::wb_req_s NET_REQ,
  input wire logic            NET_ACK,
  input wire logic            IRQ,
  input wire logic [15:0]     POLL
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // a request is taken only while no ack is showing
  sequence s_cpu_take; CPU_REQ.cyc && CPU_REQ.stb && !CPU_RSP.ack; endsequence
  sequence s_host_take; HOST_REQ.cyc && HOST_REQ.stb && !HOST_RSP.ack; endsequence
  AST_CPU_ACK: assert property (s_cpu_take |=> CPU_RSP.ack ##1 !CPU_RSP.ack)
    else $error("cpu ack");
  AST_HOST_ACK: assert property (s_host_take |=> HOST_RSP.ack ##1 !HOST_RSP.ack)
    else $error("host ack");
  AST_CPU_CAUSE: assert property (CPU_RSP.ack |-> $past(CPU_REQ.cyc && CPU_REQ.stb))
    else $error("cpu stray ack");
  AST_HOST_CAUSE: assert property (HOST_RSP.ack |-> $past(HOST_REQ.cyc && HOST_REQ.stb))
    else $error("host stray ack");
  // a queued word must stand until the far end takes it
  AST_NET_HOLD: assert property (NET_REQ.cyc && !NET_ACK |=> NET_REQ.cyc && $stable(NET_REQ))
    else $error("net word moved");
  AST_NET_IDLE: assert property (!REMOTE |-> !NET_REQ.cyc)
    else $error("host variant drove link");
  AST_IRQ_NET: assert property (REMOTE |-> !IRQ)
    else $error("network variant irq");
  // a slot only turns non-empty after a producer write
  AST_POLL_RISE: assert property (|(POLL & ~$past(POLL)) |-> HOST_RSP.ack || $past(HOST_RSP.ack)
    || $past(HOST_RSP.ack, 2) || $past(HOST_RSP.ack, 3)) else $error("poll rose alone");
endmodule : mq_checker
bind slotted_message_queue mq_checker #(.REMOTE(REMOTE)) i_chk (.CORE_CLK, .RST, .CPU_REQ,
  .CPU_RSP, .HOST_REQ, .HOST_RSP, .NET_REQ, .NET_ACK, .IRQ, .POLL);

// File: testbench/net_core_model.sv
// stand-in for the network master core
`timescale 1ns/1ps
module net_core_model (
  // clock and reset
  input wire logic            clk,
  input wire logic            rst,
  // link
  input wire mq_pkg::wb_req_s req,
  output logic                ack_q
);
  // acks at most every other cycle, so the queue always meets a slow far end
  always_ff @(posedge clk) begin
    ack_q <= !rst && req.cyc && !ack_q;
  end
endmodule : net_core_model

// File: testbench/tb_slotted_message_queue.sv
// self-checking bench for the slotted message queue
`timescale 1ns/1ps
module tb_slotted_message_queue;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            host_err = 1'b0;
  logic            net_ack;
  logic            irq;
  logic [15:0]     poll;
  mq_pkg::wb_req_s cpu_req = '0;
  mq_pkg::wb_req_s host_req = '0;
  mq_pkg::wb_req_s net_req;
  mq_pkg::wb_rsp_s cpu_rsp;
  mq_pkg::wb_rsp_s host_rsp;
  mq_pkg::wb_req_s ncpu_req = '0;
  mq_pkg::wb_rsp_s ncpu_rsp;
  mq_pkg::wb_req_s net_last = '0;
  logic [31:0]     n_ip;
  logic [31:0]     n_port;
  logic            n_irq;
  int              net_words = 0;
  int              error_cnt = 0;
  int              compares = 0;
  localparam logic [31:0] IN3 = 32'h0000_4C00;
  localparam logic [31:0] OUT0 = 32'h0000_8000;
  initial forever #5 clk = ~clk;
  slotted_message_queue i_dut (.CORE_CLK(clk), .RST(rst), .CPU_REQ(cpu_req), .CPU_RSP(cpu_rsp),
    .HOST_REQ(host_req), .HOST_RSP(host_rsp), .HOST_ERR(host_err), .NET_REQ(),
    .NET_ACK(1'b0), .NET_IP(), .NET_PORT(), .IRQ(irq), .POLL(poll));
  // network-side variant, drained by the far-end model
  slotted_message_queue #(.REMOTE(1'b1)) i_dut_net (.CORE_CLK(clk), .RST(rst),
    .CPU_REQ(ncpu_req), .CPU_RSP(ncpu_rsp), .HOST_REQ('0), .HOST_RSP(), .HOST_ERR(1'b0),
    .NET_REQ(net_req), .NET_ACK(net_ack), .NET_IP(n_ip), .NET_PORT(n_port), .IRQ(n_irq),
    .POLL());
  net_core_model i_net (.clk(clk), .rst(rst), .req(net_req), .ack_q(net_ack));
  // words the far end has taken, the last one kept for checking
  always @(posedge clk) if (net_ack && net_req.cyc) begin
    net_words <= net_words + 1;
    net_last  <= net_req;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one access; h picks the port (0 cpu, 1 host, 2 network-side cpu), reads compare against d
  task automatic acc(input logic [1:0] h, input bit w, input logic [31:0] a, d);
    int              n;
    mq_pkg::wb_rsp_s ak;
    n = 0;
    ak = '0;
    @(negedge clk);
    if (h == 2'h2) ncpu_req = '{1'b1, 1'b1, w, 4'hF, a, d};
    else if (h == 2'h1) host_req = '{1'b1, 1'b1, w, 4'hF, a, d};
    else cpu_req = '{1'b1, 1'b1, w, 4'hF, a, d};
    // request stands until the edge at which ack is seen high; data taken there too
    do begin
      @(posedge clk);
      n++;
      ak = (h == 2'h2) ? ncpu_rsp : ((h == 2'h1) ? host_rsp : cpu_rsp);
    end while (ak.ack !== 1'b1 && n < 8);
    @(negedge clk);
    if (h == 2'h2) ncpu_req = '0;
    else if (h == 2'h1) host_req = '0;
    else cpu_req = '0;
    chk("ack", 32'h1, {31'h0, ak.ack});
    if (!w) chk($sformatf("rd %h", a), d, ak.dat);
  endtask : acc
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // ---
  // tests
  // ---
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    acc(0, 0, 32'h0, 32'h0000_1010);
    acc(0, 0, 32'h4, 32'hFFFF_0000);
    acc(1, 1, IN3, 32'h1);
    acc(1, 1, IN3 + 32'h204, 32'h5A5A_0002);
    acc(1, 1, IN3, 32'h0002_0002);
    acc(0, 0, IN3 + 32'h4, 32'h0002_0100);
    acc(1, 0, IN3 + 32'h4, 32'h0002_0100);
    acc(0, 0, IN3 + 32'h204, 32'h5A5A_0002);
    chk("poll", 32'h8, {16'h0, poll});
    acc(0, 1, 32'h8, 32'h8);
    @(negedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    acc(0, 1, IN3, 32'h4);
    acc(0, 0, IN3 + 32'h4, 32'h2);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test message done");
    // three commits into a two-deep slot; the third claim erases the oldest
    for (int i = 0; i < 3; i++) begin
      acc(1, 1, IN3, 32'h1);
      acc(1, 1, IN3, 32'h0001_0002);
    end
    acc(0, 0, IN3 + 32'h4, 32'h0001_0201);
    acc(1, 1, IN3, 32'h1);
    acc(0, 0, IN3 + 32'h4, 32'h0001_0100);
    acc(1, 1, IN3, 32'h8);
    acc(0, 0, IN3 + 32'h4, 32'h2);
    acc(1, 1, IN3, 32'h1);
    host_err = 1'b1;
    acc(1, 1, IN3 + 32'h200, 32'h1);
    host_err = 1'b0;
    acc(1, 1, IN3, 32'h0001_0002);
    acc(0, 0, IN3 + 32'h4, 32'h2);
    $display("test overflow done");
    acc(0, 1, OUT0, 32'h1);
    acc(0, 1, OUT0 + 32'h200, 32'hC0DE_0001);
    acc(0, 1, OUT0, 32'h0001_0002);
    acc(1, 0, OUT0 + 32'h200, 32'hC0DE_0001);
    acc(1, 0, OUT0 + 32'h4, 32'h0001_0100);
    acc(0, 0, 32'h2000, 32'h0);
    $display("test outgoing done");
    // network-side variant: one-word message out of a slot this core owns alone
    acc(2'h2, 1, OUT0 + 32'h8, 32'h0A00_0001);
    acc(2'h2, 1, OUT0 + 32'hC, 32'h0000_EB00);
    acc(2'h2, 1, OUT0 + 32'h10, 32'h0000_4400);
    acc(2'h2, 0, OUT0 + 32'h8, 32'h0A00_0001);
    acc(2'h2, 0, OUT0 + 32'h4, 32'h2);
    acc(2'h2, 1, OUT0, 32'h1);
    acc(2'h2, 1, OUT0 + 32'h200, 32'hBEEF_0001);
    acc(2'h2, 1, OUT0, 32'h0001_0002);
    // scan, three queued words and a slow far end fit well inside this wait
    repeat (60) @(negedge clk);
    chk("net words", 32'h3, net_words);
    chk("net adr", 32'h0000_4400, net_last.adr);
    chk("net dat", 32'h0001_0002, net_last.dat);
    chk("net ip", 32'h0A00_0001, n_ip);
    chk("net port", 32'h0000_EB00, n_port);
    chk("net irq", 32'h0, {31'h0, n_irq});
    acc(2'h2, 0, OUT0 + 32'h4, 32'h2);
    $display("test network done");
    print_verdict();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule : tb_slotted_message_queue
